/* File: code_port_pkg.sv */
/*
 * Package for the host and compressed-data port of the image codec.
 * Assumes a single 20 MHz clock (the doubled video clock) and synchronous pins.
 */
package code_port_pkg;

	// ==========================================================
	// Widths and sizes
	localparam int unsigned BYTE_W       = 8;
	localparam int unsigned WORD_W       = 16;
	localparam int unsigned MEM_DEPTH    = 1024;
	localparam int unsigned MEM_AW       = 10;
	localparam int unsigned FIFO_DEPTH   = 16;

	// ==========================================================
	// Host address map on the 2-bit address
	localparam logic [1:0] ADDR_CODE     = 2'h0;
	localparam logic [1:0] ADDR_IDX_LO   = 2'h1;
	localparam logic [1:0] ADDR_IDX_HI   = 2'h2;
	localparam logic [1:0] ADDR_MEM_DATA = 2'h3;

	// ==========================================================
	// Timing: release pulse of ack and hold lines in clock cycles
	localparam real         CLK_PERIOD_NS     = 50.0;
	localparam real         RELEASE_TIME_NS   = 50.0;
	localparam int unsigned RELEASE_CYCLES    = (RELEASE_TIME_NS / CLK_PERIOD_NS < 1.0) ? 1 :
		int'(RELEASE_TIME_NS / CLK_PERIOD_NS);

	// ==========================================================
	// Reset values
	localparam logic [MEM_AW-1:0] IDX_RESET = 10'h000;

	// ==========================================================
	// Initiator strobe sequencer states
	typedef enum logic [1:0]
	{
		INI_IDLE   = 2'b00,
		INI_SETUP  = 2'b01,
		INI_STROBE = 2'b10,
		INI_END    = 2'b11
	} ini_state_e;

endpackage

/* File: code_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module code_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
)(
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// ==========================================================
	// Pointer and count update.
	always_comb
	begin
		push  = in_valid_in && in_ready_out;
		pop   = out_valid_out && out_ready_in;
		wr_d  = push ? wr_q + 1'b1 : wr_q;
		rd_d  = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Registers the pointers and stores pushed words.
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push)
			mem_q[wr_q] <= in_data_in;
	end

	// Full and empty come straight from the count.
	assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];

endmodule // code_fifo

/* File: code_host_port.sv */
/*
 * Host port and compressed-data port of the codec.
 * Assumes a 20 MHz doubled video clock; all pins are synchronous to it; the
 * core sees compressed bytes through the stream ports on the user side.
 */
// Behaviour
// - Initiator mode moves compressed bytes over the 8-bit code bus.
// - 16-bit target mode uses the code bus as upper data byte.
// - Initiator select goes low per cycle; stays low back to back on writes, goes high between reads.
// - Read strobe comes one clock after select; data taken at its rise.
// - Write strobe comes one clock after select; data held throughout.
// - Select and strobes are high in reset and until a transfer.
// - Low hold line from the external FIFO stalls initiator transfers.
// - As target, hold line low when internal FIFO empty or full.
// - Releasing hold, drive high one clock, then float.
// - Data bus carries memory access, and code data in target mode.
// - Address selects code register or indirect memory registers.
// - Writes capture data bus, plus code bus in 16-bit, on rise.
// - Reads drive data bus, plus code bus in 16-bit, during pulse.
// - Ack withheld on code access while internal FIFO empty or full.
// - Ack release drives high one cycle, then floats.
// - Buses float and hold line is input during and after reset; target compression drives hold low as soon as reset ends.
`timescale 1ns/10ps
module code_host_port
(
	input  wire logic                            sys_clk_in,
	input  wire logic                            rst_in,
	// Mode straps from the core.
	input  wire logic                            initiator_mode_in,
	input  wire logic                            wide_target_in,
	input  wire logic                            compress_in,
	// Host pins.
	input  wire logic                            host_cs_n_in,
	input  wire logic                            host_wr_n_in,
	input  wire logic                            host_rd_n_in,
	input  wire logic [1:0]                      host_addr_in,
	input  wire logic [code_port_pkg::BYTE_W-1:0] host_data_in,
	output logic      [code_port_pkg::BYTE_W-1:0] host_data_out,
	output logic                                 host_data_oe_out,
	output logic                                 host_ack_n_out,
	output logic                                 host_ack_oe_out,
	// Code bus and external FIFO pins.
	input  wire logic [code_port_pkg::BYTE_W-1:0] code_data_in,
	output logic      [code_port_pkg::BYTE_W-1:0] code_data_out,
	output logic                                 code_data_oe_out,
	output logic                                 fifo_select_n_out,
	output logic                                 fifo_read_strobe_n_out,
	output logic                                 fifo_write_strobe_n_out,
	input  wire logic                            fifo_hold_n_in,
	output logic                                 fifo_hold_n_out,
	output logic                                 fifo_hold_oe_out,
	// Core side: bytes produced by compression.
	input  wire logic                            core_tx_valid_in,
	output logic                                 core_tx_ready_out,
	input  wire logic [code_port_pkg::BYTE_W-1:0] core_tx_data_in,
	// Core side: bytes consumed by decompression.
	output logic                                 core_rx_valid_out,
	input  wire logic                            core_rx_ready_in,
	output logic      [code_port_pkg::BYTE_W-1:0] core_rx_data_out
);
	import code_port_pkg::*;

	// ==========================================================
	// Internal code FIFO, direction set by compress_in
	logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [BYTE_W-1:0] f_in_data, f_out_data;

	code_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) i_code_fifo (
		.sys_clk_in    (sys_clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (f_in_valid),
		.in_ready_out  (f_in_ready),
		.in_data_in    (f_in_data),
		.out_valid_out (f_out_valid),
		.out_ready_in  (f_out_ready),
		.out_data_out  (f_out_data)
	);

	// ==========================================================
	// Host strobe edge detection and state registers
	logic              wr_n_q, rd_n_q;
	logic              wr_rise, rd_rise, rd_fall;
	logic [MEM_AW-1:0] idx_q, idx_d;
	logic [BYTE_W-1:0] mem_q [MEM_DEPTH];
	logic [BYTE_W-1:0] rd_data_q, rd_data_d, rd_hi_q, rd_hi_d;
	logic              rd_act_q, rd_act_d;
	logic              ack_n_q, ack_n_d, ack_oe_q, ack_oe_d;
	logic              hold_n_q, hold_n_d, hold_oe_q, hold_oe_d;
	logic              code_acc, code_blocked, code_wr, code_rd, odd_q, odd_d;
	logic              host_push, host_pop, mem_wr;
	logic [BYTE_W-1:0] wide_hi_q, wide_hi_d;
	logic              wide_pend_q, wide_pend_d;

	assign wr_rise = !wr_n_q && host_wr_n_in;
	assign rd_rise = !rd_n_q && host_rd_n_in;
	assign rd_fall = rd_n_q && !host_rd_n_in && !host_cs_n_in;

	// Code register access only exists in target mode.
	always_comb
	begin
		code_acc     = !initiator_mode_in && !host_cs_n_in && (host_addr_in == ADDR_CODE);
		code_blocked = compress_in ? !f_out_valid : !f_in_ready;
		code_wr      = code_acc && wr_rise && !compress_in;
		code_rd      = code_acc && rd_fall && compress_in;
		mem_wr       = !host_cs_n_in && wr_rise && (host_addr_in == ADDR_MEM_DATA);
	end

	// Host register, memory and target-mode data path.
	always_comb
	begin
		idx_d       = idx_q;
		rd_data_d   = rd_data_q;
		rd_hi_d     = rd_hi_q;
		rd_act_d    = rd_act_q;
		odd_d       = odd_q;
		wide_hi_d   = wide_hi_q;
		wide_pend_d = wide_pend_q;
		host_push   = 1'b0;
		host_pop    = 1'b0;
		if (!host_cs_n_in && wr_rise)
		begin
			case (host_addr_in)
				ADDR_IDX_LO:   idx_d[BYTE_W-1:0] = host_data_in;
				ADDR_IDX_HI:   idx_d[MEM_AW-1:BYTE_W] = host_data_in[MEM_AW-BYTE_W-1:0];
				ADDR_MEM_DATA: idx_d = idx_q + 1'b1;
				default:       idx_d = idx_q;
			endcase
		end
		if (code_wr && !code_blocked)
		begin
			host_push = 1'b1;
			if (wide_target_in)
			begin
				wide_hi_d   = code_data_in;
				wide_pend_d = 1'b1;
			end
		end
		if (rd_fall)
		begin
			rd_act_d = 1'b1;
			case (host_addr_in)
				ADDR_IDX_LO:   rd_data_d = idx_q[BYTE_W-1:0];
				ADDR_IDX_HI:   rd_data_d = BYTE_W'(idx_q[MEM_AW-1:BYTE_W]);
				ADDR_MEM_DATA: rd_data_d = mem_q[idx_q];
				default:       rd_data_d = f_out_data;
			endcase
			if (code_rd && f_out_valid)
			begin
				host_pop = 1'b1;
				odd_d    = wide_target_in;
			end
		end
		else if (odd_q && f_out_valid)
		begin
			// Second byte of a wide read goes on the code bus.
			rd_hi_d  = f_out_data;
			host_pop = 1'b1;
			odd_d    = 1'b0;
		end
		if (!host_cs_n_in && rd_rise && (host_addr_in == ADDR_MEM_DATA))
			idx_d = idx_q + 1'b1;
		if (rd_rise || host_cs_n_in)
			rd_act_d = 1'b0;
		if (wide_pend_q && !host_push && f_in_ready)
			wide_pend_d = 1'b0;
	end

	// Ack low on an unblocked access, hold low while blocked; each high one cycle, then float.
	always_comb
	begin
		ack_n_d   = 1'b1;
		ack_oe_d  = 1'b0;
		hold_n_d  = 1'b1;
		hold_oe_d = 1'b0;
		if (!host_cs_n_in && !(code_acc && code_blocked) && (!host_wr_n_in || !host_rd_n_in))
		begin
			ack_n_d  = 1'b0;
			ack_oe_d = 1'b1;
		end
		else if (!ack_n_q && ack_oe_q)
			ack_oe_d = 1'b1;
		if (!initiator_mode_in && code_blocked)
		begin
			hold_n_d  = 1'b0;
			hold_oe_d = 1'b1;
		end
		else if (!hold_n_q && hold_oe_q)
			hold_oe_d = 1'b1;
	end

	// Registers the host side state; reset floats every two-way pin.
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			wr_n_q      <= 1'b1;
			rd_n_q      <= 1'b1;
			idx_q       <= IDX_RESET;
			rd_data_q   <= '0;
			rd_hi_q     <= '0;
			rd_act_q    <= 1'b0;
			odd_q       <= 1'b0;
			wide_hi_q   <= '0;
			wide_pend_q <= 1'b0;
			ack_n_q     <= 1'b1;
			ack_oe_q    <= 1'b0;
			hold_n_q    <= 1'b1;
			hold_oe_q   <= 1'b0;
		end
		else
		begin
			wr_n_q      <= host_wr_n_in;
			rd_n_q      <= host_rd_n_in;
			idx_q       <= idx_d;
			rd_data_q   <= rd_data_d;
			rd_hi_q     <= rd_hi_d;
			rd_act_q    <= rd_act_d;
			odd_q       <= odd_d;
			wide_hi_q   <= wide_hi_d;
			wide_pend_q <= wide_pend_d;
			ack_n_q     <= ack_n_d;
			ack_oe_q    <= ack_oe_d;
			hold_n_q    <= hold_n_d;
			hold_oe_q   <= hold_oe_d;
		end
		if (mem_wr)
			mem_q[idx_q] <= host_data_in;
	end

	// ==========================================================
	// Initiator sequencer driving select and strobes
	ini_state_e        ini_q, ini_d;
	logic              sel_n_q, sel_n_d, stb_n_q, stb_n_d;
	logic [BYTE_W-1:0] cap_q, cap_d, wdat_q, wdat_d;
	logic              cap_v_q, cap_v_d;
	logic              ini_pop, ini_push, want;

	// Compression writes when a byte waits; decompression reads when room exists.
	assign want = initiator_mode_in && fifo_hold_n_in &&
		(compress_in ? f_out_valid : (f_in_ready && !cap_v_q));

	// Strobe sits in the middle of a three-clock cycle: setup, strobe, then rise.
	always_comb
	begin
		ini_d    = ini_q;
		sel_n_d  = sel_n_q;
		stb_n_d  = 1'b1;
		cap_d    = cap_q;
		cap_v_d  = cap_v_q && !ini_push;
		wdat_d   = wdat_q;
		ini_pop  = 1'b0;
		ini_push = cap_v_q && !host_push;
		case (ini_q)
			INI_IDLE:
			begin
				sel_n_d = 1'b1;
				if (want)
				begin
					ini_d   = INI_SETUP;
					sel_n_d = 1'b0;
					if (compress_in)
					begin
						wdat_d  = f_out_data;
						ini_pop = 1'b1;
					end
				end
			end
			INI_SETUP:
			begin
				ini_d   = INI_STROBE;
				stb_n_d = 1'b0;
			end
			INI_STROBE:
			begin
				ini_d = INI_END;
				if (!compress_in)
				begin
					cap_d   = code_data_in;
					cap_v_d = 1'b1;
				end
			end
			INI_END:
			begin
				if (want)
				begin
					ini_d = INI_SETUP;
					if (compress_in)
					begin
						wdat_d  = f_out_data;
						ini_pop = 1'b1;
					end
				end
				else
				begin
					ini_d   = INI_IDLE;
					sel_n_d = 1'b1;
				end
			end
			default:
			begin
				ini_d   = INI_IDLE;
				sel_n_d = 1'b1;
			end
		endcase
	end

	// Registers the initiator state.
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ini_q   <= INI_IDLE;
			sel_n_q <= 1'b1;
			stb_n_q <= 1'b1;
			cap_q   <= '0;
			cap_v_q <= 1'b0;
			wdat_q  <= '0;
		end
		else
		begin
			ini_q   <= ini_d;
			sel_n_q <= sel_n_d;
			stb_n_q <= stb_n_d;
			cap_q   <= cap_d;
			cap_v_q <= cap_v_d;
			wdat_q  <= wdat_d;
		end
	end

	// ==========================================================
	// FIFO steering between core, host and external FIFO
	always_comb
	begin
		if (compress_in)
		begin
			f_in_valid  = core_tx_valid_in;
			f_in_data   = core_tx_data_in;
			f_out_ready = host_pop || ini_pop;
		end
		else
		begin
			f_in_valid  = host_push || ini_push || (wide_pend_q && !host_push);
			f_in_data   = host_push ? host_data_in : (ini_push ? cap_q : wide_hi_q);
			f_out_ready = core_rx_ready_in;
		end
	end

	assign core_tx_ready_out = compress_in && f_in_ready;
	assign core_rx_valid_out = !compress_in && f_out_valid;
	assign core_rx_data_out  = f_out_data;

	// Pin outputs; reads drive data only during the read pulse.
	assign host_data_out           = rd_data_q;
	assign host_data_oe_out        = rd_act_q && !host_rd_n_in && !host_cs_n_in;
	assign host_ack_n_out          = ack_n_q;
	assign host_ack_oe_out         = ack_oe_q;
	assign fifo_select_n_out       = sel_n_q;
	assign fifo_read_strobe_n_out  = stb_n_q || compress_in;
	assign fifo_write_strobe_n_out = stb_n_q || !compress_in;
	assign fifo_hold_n_out         = hold_n_q;
	assign fifo_hold_oe_out        = hold_oe_q;
	assign code_data_out           = initiator_mode_in ? wdat_q : rd_hi_q;
	assign code_data_oe_out        = initiator_mode_in ? (compress_in && !sel_n_q) :
		(wide_target_in && host_data_oe_out);

endmodule // code_host_port

/* File: code_host_port_chk.sv */
/*
 * Checker of the code_host_port pins, bound to every instance.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module code_host_port_chk
	import code_port_pkg::*;
(
	input wire logic              sys_clk_in,
	input wire logic              rst_in,
	input wire logic              initiator_mode_in,
	input wire logic              host_cs_n_in,
	input wire logic              host_rd_n_in,
	input wire logic [1:0]        host_addr_in,
	input wire logic              host_data_oe_out,
	input wire logic              host_ack_n_out,
	input wire logic              host_ack_oe_out,
	input wire logic [BYTE_W-1:0] code_data_out,
	input wire logic              code_data_oe_out,
	input wire logic              fifo_select_n_out,
	input wire logic              fifo_read_strobe_n_out,
	input wire logic              fifo_write_strobe_n_out,
	input wire logic              fifo_hold_n_in,
	input wire logic              fifo_hold_n_out,
	input wire logic              fifo_hold_oe_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// =========================================
	// Sequences

	// One strobe low for a cycle, then high again.
	sequence seq_strobe_pulse;
		(!fifo_read_strobe_n_out || !fifo_write_strobe_n_out)
			##1 (fifo_read_strobe_n_out && fifo_write_strobe_n_out);
	endsequence

	// =========================================
	// Assertions
	AST_RST_IDLE: assert property (disable iff (1'h0) rst_in |=>
		(fifo_select_n_out && fifo_read_strobe_n_out && fifo_write_strobe_n_out
		&& !host_data_oe_out && !code_data_oe_out && !fifo_hold_oe_out))
		else $error("Pins not idle after reset.");
	AST_STROBE_IN_SELECT: assert property (
		(!fifo_read_strobe_n_out || !fifo_write_strobe_n_out) |-> !fifo_select_n_out)
		else $error("Strobe low outside select.");
	AST_STROBE_DELAY: assert property ($fell(fifo_select_n_out) |=> seq_strobe_pulse)
		else $error("Strobe not one cycle after select.");
	AST_WDATA_HELD: assert property (!fifo_write_strobe_n_out |->
		code_data_oe_out && $stable(code_data_out))
		else $error("Write data moved in strobe.");
	AST_HOLD_STALL: assert property (
		initiator_mode_in && !fifo_hold_n_in && fifo_select_n_out |=> fifo_select_n_out)
		else $error("Cycle started while held.");
	AST_TARGET_QUIET: assert property (!initiator_mode_in |->
		fifo_select_n_out && fifo_read_strobe_n_out && fifo_write_strobe_n_out)
		else $error("Code strobes active in target mode.");
	AST_HOLD_RELEASE: assert property (
		fifo_hold_oe_out && $rose(fifo_hold_n_out) |=> !fifo_hold_oe_out)
		else $error("Hold line not floated after release.");
	AST_ACK_RELEASE: assert property (
		host_ack_oe_out && $rose(host_ack_n_out) |=> !host_ack_oe_out)
		else $error("Ack not floated after release.");
	AST_ACK_CAUSE: assert property (
		host_ack_oe_out && !host_ack_n_out |-> $past(!host_cs_n_in))
		else $error("Ack without host select.");
	AST_READ_DRIVE: assert property (
		host_data_oe_out |-> !host_rd_n_in && !host_cs_n_in)
		else $error("Data driven outside read pulse.");
	AST_READ_START: assert property (
		$fell(host_rd_n_in) && !host_cs_n_in && host_addr_in != ADDR_CODE |=> host_data_oe_out)
		else $error("Read data not driven.");
endmodule // code_host_port_chk

bind code_host_port code_host_port_chk i_code_host_port_chk (.sys_clk_in, .rst_in,
	.initiator_mode_in, .host_cs_n_in, .host_rd_n_in, .host_addr_in, .host_data_oe_out,
	.host_ack_n_out, .host_ack_oe_out, .code_data_out, .code_data_oe_out,
	.fifo_select_n_out, .fifo_read_strobe_n_out, .fifo_write_strobe_n_out,
	.fifo_hold_n_in, .fifo_hold_n_out, .fifo_hold_oe_out);

/* File: code_fifo_partner.sv */
/*
 * Model of the external compressed-data FIFO used in initiator mode.
 * Assumes the bench resolves the code bus and the pulled-up hold line.
 */
`timescale 1ns/10ps
module code_fifo_partner
(
	input  wire logic       rst_in,
	input  wire logic       sel_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       wr_n_in,
	input  wire logic [7:0] bus_in,
	input  wire logic       stall_in,
	output logic      [7:0] data_out,
	output logic            oe_out,
	output logic            hold_n_out
);
	logic [7:0] got [0:15];
	logic [7:0] nxt = 8'hA0;
	int         n = 0;

	// =========================================
	// Sink and source

	// Bytes are taken on the rising edge of the write strobe.
	always @(posedge wr_n_in or posedge rst_in)
		if (rst_in)
			n <= 0;
		else if (!sel_n_in)
		begin
			got[n[3:0]] <= bus_in;
			n <= n + 1;
		end

	// The source moves on to the next byte when the read strobe rises.
	always @(posedge rd_n_in or posedge rst_in)
		if (rst_in)
			nxt <= 8'hA0;
		else if (!sel_n_in)
			nxt <= nxt + 8'h01;

	// The bus is driven only during a selected read; hold is pulled low on a stall.
	assign oe_out = !sel_n_in && !rd_n_in;
	assign data_out = nxt;
	assign hold_n_out = !stall_in;
endmodule // code_fifo_partner

/* File: code_host_port_bench.sv */
/*
 * Self-checking bench of code_host_port with the external FIFO model.
 * Assumes the checker is bound; inputs change at falling edges.
 */
`timescale 1ns/10ps
module code_host_port_bench;
	import code_port_pkg::*;
	logic       sys_clk_in = 1'h0;
	logic       rst_in = 1'h1;
	logic       ini = 1'h0, wide = 1'h0, comp = 1'h0, stall = 1'h0;
	logic       cs_n = 1'h1, wr_n = 1'h1, rd_n = 1'h1, hwe = 1'h0, fifo_write_strobe_n = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] hdrv = 8'h00, cdrv = 8'h00, tx_d = 8'h00, q, qh;
	logic       tx_v = 1'h0, rx_r = 1'h0, ok;
	logic [1:0] rel;
	wire  [7:0] hq, cq, rx_d, pd, host_bus, code_bus;
	wire        hoe, ack_n, ack_oe, fifo_read_strobe_n, sel_n, rds_n, wrs_n, hold_q, hold_oe;
	wire        tx_r, rx_v, poe, ph, hold_bus;
	int         n_errors = 0;
	int         comparisons = 0;

	// =========================================
	// Clock, pins and instances

	// The clock toggles every 25 ns, half of its 50 ns period.
	always #25 sys_clk_in = ~sys_clk_in;

	// Released lines fall back to their pull-ups.
	assign host_bus = hoe ? hq : (hwe ? hdrv : 8'hFF);
	assign code_bus = fifo_read_strobe_n ? cq : (poe ? pd : (fifo_write_strobe_n ? cdrv : 8'hFF));
	assign hold_bus = hold_oe ? hold_q : ph;

	code_host_port i_code_host_port (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.initiator_mode_in(ini), .wide_target_in(wide), .compress_in(comp),
		.host_cs_n_in(cs_n), .host_wr_n_in(wr_n), .host_rd_n_in(rd_n),
		.host_addr_in(addr), .host_data_in(host_bus), .host_data_out(hq),
		.host_data_oe_out(hoe), .host_ack_n_out(ack_n), .host_ack_oe_out(ack_oe),
		.code_data_in(code_bus), .code_data_out(cq), .code_data_oe_out(fifo_read_strobe_n),
		.fifo_select_n_out(sel_n), .fifo_read_strobe_n_out(rds_n),
		.fifo_write_strobe_n_out(wrs_n), .fifo_hold_n_in(hold_bus),
		.fifo_hold_n_out(hold_q), .fifo_hold_oe_out(hold_oe),
		.core_tx_valid_in(tx_v), .core_tx_ready_out(tx_r), .core_tx_data_in(tx_d),
		.core_rx_valid_out(rx_v), .core_rx_ready_in(rx_r), .core_rx_data_out(rx_d));

	code_fifo_partner i_code_fifo_partner (.rst_in(rst_in), .sel_n_in(sel_n),
		.rd_n_in(rds_n), .wr_n_in(wrs_n), .bus_in(code_bus), .stall_in(stall),
		.data_out(pd), .oe_out(poe), .hold_n_out(ph));

	// =========================================
	// Shared tasks

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Counts a hang as a mismatch and closes the run.
	task automatic fail(input string nm);
		chk(nm, 16'h0001, 16'h0000);
		complete_run();
	endtask

	// Holds reset for eight cycles with the given mode straps.
	task automatic start(input logic i, input logic w, input logic c);
		@(negedge sys_clk_in);
		{ini, wide, comp, rst_in} = {i, w, c, 1'h1};
		repeat (8) @(negedge sys_clk_in);
		chk("reset pins", 16'h0038, {sel_n, rds_n, wrs_n, hoe, fifo_read_strobe_n, hold_oe});
		rst_in = 1'h0;
	endtask

	// One host access; select and data stay up over the strobe's rise, since the
	// device takes the access at that edge; ok tells whether ack came.
	task automatic host(input logic w, input logic [1:0] a, input logic [7:0] d, dh);
		@(negedge sys_clk_in);
		{cs_n, addr, hdrv, cdrv, hwe, fifo_write_strobe_n} = {1'h0, a, d, dh, w, w & wide};
		{wr_n, rd_n} = {~w, w};
		ok = 1'h0;
		for (int i = 0; i < 12 && !ok; i++)
		begin
			@(negedge sys_clk_in);
			ok = (ack_n === 1'h0);
		end
		@(negedge sys_clk_in);
		{q, qh} = {host_bus, code_bus};
		{wr_n, rd_n} = 2'h3;
		@(negedge sys_clk_in);
		rel = {ack_oe, ack_n};
		{cs_n, hwe, fifo_write_strobe_n} = 3'h4;
		@(negedge sys_clk_in);
	endtask

	// Hands one byte to the core transmit port.
	task automatic push(input logic [7:0] d);
		int i;
		@(negedge sys_clk_in);
		{tx_v, tx_d} = {1'h1, d};
		for (i = 0; i < 100 && tx_r !== 1'h1; i++) @(negedge sys_clk_in);
		if (i == 100) fail("tx ready");
		@(negedge sys_clk_in);
		tx_v = 1'h0;
	endtask

	// Takes one byte from the core receive port and compares it.
	task automatic pop(input logic [7:0] e);
		int i;
		@(negedge sys_clk_in);
		rx_r = 1'h1;
		for (i = 0; i < 100 && rx_v !== 1'h1; i++) @(negedge sys_clk_in);
		if (i == 100) fail("rx valid");
		chk("rx byte", e, rx_d);
		@(negedge sys_clk_in);
		rx_r = 1'h0;
	endtask

	// =========================================
	// Scenarios

	// Indirect memory writes and reads with index auto-increment.
	task automatic t_mem();
		start(1'h0, 1'h0, 1'h0);
		host(1'h1, ADDR_IDX_LO, 8'h05, 8'h00);
		chk("ack release", 16'h0006, {13'h0000, rel, ack_oe});
		host(1'h1, ADDR_IDX_HI, 8'h01, 8'h00);
		host(1'h1, ADDR_MEM_DATA, 8'h3C, 8'h00);
		host(1'h1, ADDR_MEM_DATA, 8'hC3, 8'h00);
		host(1'h1, ADDR_IDX_LO, 8'h05, 8'h00);
		host(1'h0, ADDR_MEM_DATA, 8'h00, 8'h00);
		chk("mem read 0", {7'h00, ok, q}, 16'h013C);
		host(1'h0, ADDR_MEM_DATA, 8'h00, 8'h00);
		chk("mem read 1", {7'h00, ok, q}, 16'h01C3);
		$display("test memory done");
	endtask

	// Target compression: refused read when empty, then two bytes.
	task automatic t_tgt_comp();
		start(1'h0, 1'h0, 1'h1);
		host(1'h0, ADDR_CODE, 8'h00, 8'h00);
		chk("empty read", {ok, hold_oe, hold_q}, 16'h0002);
		push(8'h5A);
		push(8'hA5);
		chk("hold released", 16'h0001, {14'h0000, hold_oe, hold_q});
		host(1'h0, ADDR_CODE, 8'h00, 8'h00);
		chk("code read 0", {7'h00, ok, q}, 16'h015A);
		host(1'h0, ADDR_CODE, 8'h00, 8'h00);
		chk("code read 1", {7'h00, ok, q}, 16'h01A5);
		$display("test target compress done");
	endtask

	// Target decompression: fill until refused, then drain in order.
	task automatic t_tgt_dec();
		start(1'h0, 1'h0, 1'h0);
		for (int i = 0; i < FIFO_DEPTH; i++)
		begin
			host(1'h1, ADDR_CODE, 8'(i * 17), 8'h00);
			chk("fill ack", {15'h0000, ok}, 16'h0001);
		end
		host(1'h1, ADDR_CODE, 8'hEE, 8'h00);
		chk("full write", {ok, hold_oe, hold_q}, 16'h0002);
		for (int i = 0; i < FIFO_DEPTH; i++) pop(8'(i * 17));
		repeat (3) @(negedge sys_clk_in);
		chk("drained", {15'h0000, rx_v}, 16'h0000);
		$display("test target decompress done");
	endtask

	// Sixteen-bit target words in both directions.
	task automatic t_wide();
		start(1'h0, 1'h1, 1'h0);
		host(1'h1, ADDR_CODE, 8'h12, 8'h34);
		pop(8'h12);
		pop(8'h34);
		start(1'h0, 1'h1, 1'h1);
		push(8'h56);
		push(8'h78);
		host(1'h0, ADDR_CODE, 8'h00, 8'h00);
		chk("wide read", {q, qh}, 16'h5678);
		$display("test wide target done");
	endtask

	// Initiator compression: stalled by hold, then a back-to-back burst.
	task automatic t_ini_comp();
		int i;
		int rises;
		logic prev;
		start(1'h1, 1'h0, 1'h1);
		stall = 1'h1;
		push(8'h5A);
		push(8'h5B);
		push(8'h5C);
		repeat (6) @(negedge sys_clk_in);
		chk("held select", {15'h0000, sel_n}, 16'h0001);
		stall = 1'h0;
		rises = 0;
		prev = 1'h1;
		for (i = 0; i < 100 && i_code_fifo_partner.n < 3; i++)
		begin
			@(negedge sys_clk_in);
			if (prev === 1'h0 && sel_n === 1'h1) rises++;
			prev = sel_n;
		end
		if (i == 100) fail("initiator writes");
		chk("select gaps", 16'(rises), 16'h0000);
		chk("fifo byte 0", 16'h005A, i_code_fifo_partner.got[0]);
		chk("fifo byte 2", 16'h005C, i_code_fifo_partner.got[2]);
		$display("test initiator compress done");
	endtask

	// Initiator decompression: bytes read from the external FIFO in order.
	task automatic t_ini_dec();
		start(1'h1, 1'h0, 1'h0);
		for (int i = 0; i < 4; i++) pop(8'hA0 + 8'(i));
		$display("test initiator decompress done");
	endtask

	// =========================================
	// Main sequence

	// Runs every scenario, then the verdict.
	initial
	begin
		t_mem();
		t_tgt_comp();
		t_tgt_dec();
		t_wide();
		t_ini_comp();
		t_ini_dec();
		complete_run();
	end
endmodule // code_host_port_bench
